// file: rtl/sesr_map.svh
// Bit positions, used masks and reset values of the status and service-request block
`ifndef SESR_MAP_SVH
`define SESR_MAP_SVH

// Standard event latch bit positions
`define SESR_STD_OPC      0
`define SESR_STD_QYE      2
`define SESR_STD_DDE      3
`define SESR_STD_EXE      4
`define SESR_STD_CME      5
`define SESR_STD_PON      7
`define SESR_STD_WIDTH    8
// Bits 1 and 6 never set
`define SESR_STD_USED     8'hBD
// Power-on bit set out of reset
`define SESR_STD_RESET    8'h80

// Questionable event latch bit positions
`define SESR_QUES_VOLT    0
`define SESR_QUES_CURR    1
`define SESR_QUES_OHMS    9
`define SESR_QUES_LIMLO   11
`define SESR_QUES_LIMHI   12
`define SESR_QUES_REMOTE  13
`define SESR_QUES_WIDTH   16
// Bits 2-8, 10, 14, 15 never set
`define SESR_QUES_USED    16'h3A03
`define SESR_QUES_RESET   16'h0000

// Status summary byte bit positions
`define SESR_SUM_QUES     3
`define SESR_SUM_MAV      4
`define SESR_SUM_ESB      5
`define SESR_SUM_RQS      6
`define SESR_SUM_WIDTH    8
// Service request mask bits that feed the master summary: 1-5 and 7
`define SESR_SVC_FEED     8'hBE

// Mask reset values
`define SESR_SVC_RESET    8'h00
`define SESR_SEM_RESET    8'h00
`define SESR_QEN_RESET    16'h0000

`endif

// file: rtl/sesr_pkg.sv
// Types and shared functions of the status and service-request block
package sesr_pkg;

  // Decoded status command from the message parser
  typedef enum logic [3:0] {
    SESR_CMD_NONE,
    SESR_CMD_SUM_Q,
    SESR_CMD_SVC_W,
    SESR_CMD_SVC_Q,
    SESR_CMD_STD_Q,
    SESR_CMD_SEM_W,
    SESR_CMD_SEM_Q,
    SESR_CMD_QEV_Q,
    SESR_CMD_QEN_W,
    SESR_CMD_QEN_Q,
    SESR_CMD_CLS
  } sesr_cmd_t;

  // Master summary: any status bit in feed whose service mask bit is set
  function automatic logic sesr_master_summary(input logic [7:0] sumByte,
                                               input logic [7:0] svcMask,
                                               input logic [7:0] feed);
    sesr_master_summary = |(sumByte & svcMask & feed);
  endfunction

endpackage

// file: rtl/sesr_event_latch.sv
// Sticky event latch with enable mask and summary bit
`timescale 1ns/10ps
module sesr_event_latch #(
  parameter int              WIDTH = 8,
  parameter logic [WIDTH-1:0] USED = '1,
  parameter logic [WIDTH-1:0] RSTV = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] setBits,
  input  wire logic             readClr,
  input  wire logic             clsClr,
  input  wire logic [WIDTH-1:0] enMask,
  output logic      [WIDTH-1:0] latch_q,
  output logic                  summary_q
);

  logic [WIDTH-1:0] setUsed;
  logic [WIDTH-1:0] rise;
  logic             anyClr;
  logic [WIDTH-1:0] latch_d;
  logic             summary_d;

  // Unused positions can never latch
  assign setUsed = setBits & USED;
  assign rise    = setUsed & ~latch_q;
  assign anyClr  = readClr | clsClr;

  // Clear drops old bits, but events of the same cycle survive
  assign latch_d = anyClr ? setUsed : (latch_q | setUsed);

  // Summary only on an enabled 0-to-1 edge; set beats clear
  assign summary_d = (|(rise & enMask)) ? 1'b1 :
                     (anyClr ? 1'b0 : summary_q);

  // Latch and summary registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_q   <= RSTV;
      summary_q <= 1'b0;
    end else begin
      latch_q   <= latch_d;
      summary_q <= summary_d;
    end
  end

endmodule

// file: rtl/sesr_status_core.sv
// Status byte, event registers and service request of the remote interface
`timescale 1ns/10ps
`include "sesr_map.svh"

////////////////////////////////////////////////////////////////////////////////
module sesr_status_core (
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Decoded command port from the message parser
  input  wire logic                cmdValid,
  input  wire sesr_pkg::sesr_cmd_t cmdCode,
  input  wire logic [15:0]         cmdData,
  output logic                     rspValid_q,
  output logic [15:0]              rspData_q,
  // Serial poll from the bus interface
  input  wire logic                pollReq,
  output logic                     pollValid_q,
  output logic [7:0]               pollByte_q,
  // Service request line, open drain
  output logic                     srqOut_q,
  output logic                     srqOeN_q,
  // Output buffer events
  input  wire logic                msgLoaded,
  input  wire logic                termSent,
  // Standard event sources, one-cycle pulses
  input  wire logic                opcDone,
  input  wire logic                queryError,
  input  wire logic                deviceError,
  input  wire logic                execError,
  input  wire logic                commandError,
  // Questionable measurement conditions
  input  wire logic                voltOverload,
  input  wire logic                currOverload,
  input  wire logic                ohmsOverload,
  input  wire logic                limitLow,
  input  wire logic                limitHigh,
  input  wire logic                remoteMode
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]  svcMask_q;
  logic [7:0]  stdMask_q;
  logic [15:0] quesMask_q;
  logic        mav_q;
  logic        rqs_q;
  logic        mssPrev_q;

  logic [7:0]  stdLatch;
  logic [15:0] quesLatch;
  logic        esbSum;
  logic        quesSum;

  logic        isCmd;
  logic        cmdCls;
  logic        cmdStdRd;
  logic        cmdQevRd;
  logic        cmdSvcWr;
  logic        cmdSemWr;
  logic        cmdQenWr;
  logic        cmdQuery;

  logic [7:0]  stdSet;
  logic [15:0] quesSet;
  logic [7:0]  sumBase;
  logic        mss;
  logic [7:0]  sumQuery;
  logic [7:0]  sumPoll;
  logic        mav_d;
  logic        rqs_d;
  logic [15:0] rspSel;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  // Only one command per cycle, so plain compares suffice
  assign isCmd    = cmdValid;
  assign cmdCls   = isCmd && (cmdCode == sesr_pkg::SESR_CMD_CLS);
  // Reading an event latch also empties it, like clear-status
  assign cmdStdRd = isCmd && (cmdCode == sesr_pkg::SESR_CMD_STD_Q);
  assign cmdQevRd = isCmd && (cmdCode == sesr_pkg::SESR_CMD_QEV_Q);
  assign cmdSvcWr = isCmd && (cmdCode == sesr_pkg::SESR_CMD_SVC_W);
  assign cmdSemWr = isCmd && (cmdCode == sesr_pkg::SESR_CMD_SEM_W);
  assign cmdQenWr = isCmd && (cmdCode == sesr_pkg::SESR_CMD_QEN_W);

  // Queries answer next cycle; writes and clear-status give no answer
  assign cmdQuery = isCmd && ((cmdCode == sesr_pkg::SESR_CMD_SUM_Q) ||
                              (cmdCode == sesr_pkg::SESR_CMD_SVC_Q) ||
                              (cmdCode == sesr_pkg::SESR_CMD_STD_Q) ||
                              (cmdCode == sesr_pkg::SESR_CMD_SEM_Q) ||
                              (cmdCode == sesr_pkg::SESR_CMD_QEV_Q) ||
                              (cmdCode == sesr_pkg::SESR_CMD_QEN_Q));

  ////////////////////////////////////////////////////////////////////////////
  // Standard event sources mapped to bit positions

  // Sources are pulses; a source held high re-latches after every clear
  always_comb begin
    stdSet                   = 8'h00;
    stdSet[`SESR_STD_OPC]    = opcDone;
    stdSet[`SESR_STD_QYE]    = queryError;
    stdSet[`SESR_STD_DDE]    = deviceError;
    stdSet[`SESR_STD_EXE]    = execError;
    stdSet[`SESR_STD_CME]    = commandError;
  end

  // Power-on bit comes from the latch reset value, not from a port
  sesr_event_latch #(
    .WIDTH (`SESR_STD_WIDTH),
    .USED  (`SESR_STD_USED),
    .RSTV  (`SESR_STD_RESET)
  ) uStdEvent (
    .clock     (clock),
    .rst_n     (rst_n),
    .setBits   (stdSet),
    .readClr   (cmdStdRd),
    .clsClr    (cmdCls),
    .enMask    (stdMask_q),
    .latch_q   (stdLatch),
    .summary_q (esbSum)
  );
  // carried by the latch instance above

  ////////////////////////////////////////////////////////////////////////////
  // Questionable condition sources mapped to bit positions

  always_comb begin
    quesSet                      = 16'h0000;
    quesSet[`SESR_QUES_VOLT]     = voltOverload;
    quesSet[`SESR_QUES_CURR]     = currOverload;
    quesSet[`SESR_QUES_OHMS]     = ohmsOverload;
    quesSet[`SESR_QUES_LIMLO]    = limitLow;
    quesSet[`SESR_QUES_LIMHI]    = limitHigh;
    quesSet[`SESR_QUES_REMOTE]   = remoteMode;
  end

  // Level inputs re-latch right after a clear while they stay high
  sesr_event_latch #(
    .WIDTH (`SESR_QUES_WIDTH),
    .USED  (`SESR_QUES_USED),
    .RSTV  (`SESR_QUES_RESET)
  ) uQuesEvent (
    .clock     (clock),
    .rst_n     (rst_n),
    .setBits   (quesSet),
    .readClr   (cmdQevRd),
    .clsClr    (cmdCls),
    .enMask    (quesMask_q),
    .latch_q   (quesLatch),
    .summary_q (quesSum)
  );
  // carried by the latch instance above

  ////////////////////////////////////////////////////////////////////////////
  // Status byte assembly

  // Bits 0-2 and 7 unused and read as zero; bit 6 filled per reader
  always_comb begin
    sumBase                  = 8'h00;
    sumBase[`SESR_SUM_QUES]  = quesSum;
    sumBase[`SESR_SUM_MAV]   = mav_q;
    sumBase[`SESR_SUM_ESB]   = esbSum;
  end

  // Master summary from bits 1-5 and 7 under the service mask
  // Mask bit 6 is stored for read-back but can never feed the summary,
  // which keeps request-service from feeding back on itself
  assign mss = sesr_pkg::sesr_master_summary(sumBase, svcMask_q,
                                             `SESR_SVC_FEED);

  // Query sees master summary, poll sees request-service
  always_comb begin
    sumQuery                 = sumBase;
    sumQuery[`SESR_SUM_RQS]  = mss;
    sumPoll                  = sumBase;
    sumPoll[`SESR_SUM_RQS]   = rqs_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message available and request service next values

  // Load beats terminator when both land together
  assign mav_d = msgLoaded ? 1'b1 : (termSent ? 1'b0 : mav_q);

  // A new rise of the master summary beats a poll's clear
  assign rqs_d = (mss && !mssPrev_q) ? 1'b1 :
                 (pollReq ? 1'b0 : rqs_q);

  ////////////////////////////////////////////////////////////////////////////
  // Query answer selection

  // Chosen in the command cycle, so a read returns bits before its clear
  always_comb begin
    rspSel = 16'h0000;
    unique case (cmdCode)
      sesr_pkg::SESR_CMD_SUM_Q: rspSel = {8'h00, sumQuery};
      sesr_pkg::SESR_CMD_SVC_Q: rspSel = {8'h00, svcMask_q};
      sesr_pkg::SESR_CMD_STD_Q: rspSel = {8'h00, stdLatch};
      sesr_pkg::SESR_CMD_SEM_Q: rspSel = {8'h00, stdMask_q};
      sesr_pkg::SESR_CMD_QEV_Q: rspSel = quesLatch;
      sesr_pkg::SESR_CMD_QEN_Q: rspSel = quesMask_q;
      default:                  rspSel = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers, writable only through their commands

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      svcMask_q  <= `SESR_SVC_RESET;
      stdMask_q  <= `SESR_SEM_RESET;
      quesMask_q <= `SESR_QEN_RESET;
    end else begin
      // Byte-wide masks ignore the upper byte of the write data
      if (cmdSvcWr) svcMask_q  <= cmdData[7:0];
      if (cmdSemWr) stdMask_q  <= cmdData[7:0];
      if (cmdQenWr) quesMask_q <= cmdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status state: message available, request service, summary edge

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mav_q     <= 1'b0;
      rqs_q     <= 1'b0;
      mssPrev_q <= 1'b0;
    end else begin
      mav_q     <= mav_d;
      rqs_q     <= rqs_d;
      mssPrev_q <= mss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Query answer register

  // Answer holds one cycle; the parser must take it then
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rspValid_q <= 1'b0;
      rspData_q  <= 16'h0000;
    end else begin
      rspValid_q <= cmdQuery;
      if (cmdQuery) rspData_q <= rspSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial poll answer register

  // Byte reflects state in the poll cycle, before the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pollValid_q <= 1'b0;
      pollByte_q  <= 8'h00;
    end else begin
      pollValid_q <= pollReq;
      if (pollReq) pollByte_q <= sumPoll;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service request line, pulled low while request-service is set

  // Registered from the next value so the line tracks rqs_q exactly
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      srqOut_q <= 1'b0;
      srqOeN_q <= 1'b1;
    end else begin
      srqOut_q <= 1'b0;
      srqOeN_q <= ~rqs_d;
    end
  end

endmodule

// file: verif/sesr_status_checker.sv
// Port-level assertions of the status and service-request block
`timescale 1ns/10ps
module sesr_status_checker (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                cmdValid,
  input wire sesr_pkg::sesr_cmd_t cmdCode,
  input wire logic                rspValid_q,
  input wire logic [15:0]         rspData_q,
  input wire logic                pollReq,
  input wire logic                pollValid_q,
  input wire logic [7:0]          pollByte_q,
  input wire logic                srqOut_q,
  input wire logic                srqOeN_q,
  input wire logic                msgLoaded,
  input wire logic                termSent
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Command decode, kept apart so properties stay short
  wire logic isSum = cmdValid && cmdCode == sesr_pkg::SESR_CMD_SUM_Q;
  wire logic isStd = cmdValid && cmdCode == sesr_pkg::SESR_CMD_STD_Q;
  wire logic isQev = cmdValid && cmdCode == sesr_pkg::SESR_CMD_QEV_Q;
  wire logic isByteQ = isSum || isStd || (cmdValid && (cmdCode == sesr_pkg::SESR_CMD_SVC_Q
                       || cmdCode == sesr_pkg::SESR_CMD_SEM_Q));
  wire logic isQuery = isByteQ || isQev || (cmdValid && cmdCode == sesr_pkg::SESR_CMD_QEN_Q);
  ////////////////////////////////////////////////////////////////////////////////
  // Answer timing and shape
  property p_query_ans; isQuery |=> rspValid_q; endproperty
  a_query_ans: assert property (p_query_ans) else $error("query without answer");
  property p_no_ans; !isQuery |=> !rspValid_q; endproperty
  a_no_ans: assert property (p_no_ans) else $error("answer without query");
  property p_byte_zext; isByteQ |=> rspData_q[15:8] == 8'h00; endproperty
  a_byte_zext: assert property (p_byte_zext) else $error("byte answer upper bits set");
  property p_sum_unused; isSum |=> rspData_q[7] == 1'b0 && rspData_q[2:0] == 3'h0; endproperty
  a_sum_unused: assert property (p_sum_unused) else $error("status byte unused bit set");
  property p_std_unused; isStd |=> rspData_q[1] == 1'b0 && rspData_q[6] == 1'b0; endproperty
  a_std_unused: assert property (p_std_unused) else $error("event unused bit set");
  property p_ques_unused; isQev |=> (rspData_q & 16'hC5FC) == 16'h0000; endproperty
  a_ques_unused: assert property (p_ques_unused) else $error("ques unused bit set");
  ////////////////////////////////////////////////////////////////////////////////
  // Serial poll and service request line
  property p_poll_ans;
    pollReq |=> pollValid_q && pollByte_q[7] == 1'b0 && pollByte_q[2:0] == 3'h0;
  endproperty
  a_poll_ans: assert property (p_poll_ans) else $error("poll answer wrong");
  property p_poll_idle; !pollReq |=> !pollValid_q; endproperty
  a_poll_idle: assert property (p_poll_idle) else $error("poll answer unasked");
  property p_rqs_seen; pollReq && !srqOeN_q |=> pollByte_q[6]; endproperty
  a_rqs_seen: assert property (p_rqs_seen) else $error("request not in poll byte");
  property p_srq_level; srqOut_q == 1'b0; endproperty
  a_srq_level: assert property (p_srq_level) else $error("service line driven high");
  property p_sum_keeps; isSum && !pollReq && !srqOeN_q |=> !srqOeN_q; endproperty
  a_sum_keeps: assert property (p_sum_keeps) else $error("status query dropped request");
  // Message available seen one cycle after the buffer event
  property p_mav_set; msgLoaded ##1 isSum |=> rspData_q[4]; endproperty
  a_mav_set: assert property (p_mav_set) else $error("message bit not set");
  property p_mav_clr; termSent && !msgLoaded ##1 isSum |=> !rspData_q[4]; endproperty
  a_mav_clr: assert property (p_mav_clr) else $error("message bit not cleared");
  c_query: cover property (isQuery ##1 rspValid_q);
  c_poll_rqs: cover property (pollReq && !srqOeN_q);
  c_mav: cover property (msgLoaded ##1 isSum);
endmodule

// file: verif/sesr_host_model.sv
// Bus host model: issues status commands and serial polls
`timescale 1ns/10ps
module sesr_host_model (
  input  wire logic           clock,
  output logic                cmdValid,
  output sesr_pkg::sesr_cmd_t cmdCode,
  output logic [15:0]         cmdData,
  output logic                pollReq,
  input  wire logic           rspValid_q,
  input  wire logic [15:0]    rspData_q,
  input  wire logic           pollValid_q,
  input  wire logic [7:0]     pollByte_q
);
  initial begin
    cmdValid = 1'b0;
    cmdCode = sesr_pkg::SESR_CMD_NONE;
    cmdData = 16'h0000;
    pollReq = 1'b0;
  end
  // One command; idle data inverted so stale data never passes
  task automatic issue(input sesr_pkg::sesr_cmd_t c, input logic [15:0] d,
                       output logic ok, output logic [15:0] r);
    @(negedge clock);
    cmdValid = 1'b1;
    cmdCode = c;
    cmdData = d;
    @(negedge clock);
    ok = rspValid_q;
    r = rspData_q;
    cmdValid = 1'b0;
    cmdData = ~d;
  endtask
  // Serial poll finds out which instrument asked for service
  task automatic poll(output logic ok, output logic [7:0] b);
    @(negedge clock);
    pollReq = 1'b1;
    @(negedge clock);
    ok = pollValid_q;
    b = pollByte_q;
    pollReq = 1'b0;
  endtask
endmodule

// file: verif/status_event_service_request_bench.sv
// Self-checking bench of the status and service-request block
`timescale 1ns/10ps
`include "sesr_map.svh"
`define SESR_CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", what, exp, got); end end
module status_event_service_request_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [12:0] ev = 13'h0000;
  int   mismatches = 0;
  int   nTests = 0;
  wire logic cmdValid, rspValid_q, pollReq, pollValid_q, srqOut_q, srqOeN_q;
  wire sesr_pkg::sesr_cmd_t cmdCode;
  wire logic [15:0] cmdData, rspData_q;
  wire logic [7:0] pollByte_q;
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  sesr_status_core DUT (.clock(clock), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .rspValid_q(rspValid_q), .rspData_q(rspData_q), .pollReq(pollReq),
    .pollValid_q(pollValid_q), .pollByte_q(pollByte_q), .srqOut_q(srqOut_q),
    .srqOeN_q(srqOeN_q), .msgLoaded(ev[11]), .termSent(ev[12]), .opcDone(ev[0]),
    .queryError(ev[1]), .deviceError(ev[2]), .execError(ev[3]), .commandError(ev[4]),
    .voltOverload(ev[5]), .currOverload(ev[6]), .ohmsOverload(ev[7]), .limitLow(ev[8]),
    .limitHigh(ev[9]), .remoteMode(ev[10]));
  sesr_host_model host (.clock(clock), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .pollReq(pollReq), .rspValid_q(rspValid_q), .rspData_q(rspData_q),
    .pollValid_q(pollValid_q), .pollByte_q(pollByte_q));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared drivers: event pulse, query with compare, write
  task automatic pulse(input int i);
    @(negedge clock);
    ev[i] = 1'b1;
    @(negedge clock);
    ev[i] = 1'b0;
  endtask
  task automatic q(input sesr_pkg::sesr_cmd_t c, input logic [15:0] e);
    logic ok;
    logic [15:0] r;
    host.issue(c, 16'h0000, ok, r);
    `SESR_CHK(c.name(), {1'b1, e}, {ok, r})
  endtask
  task automatic w(input sesr_pkg::sesr_cmd_t c, input logic [15:0] d);
    logic ok;
    logic [15:0] r;
    host.issue(c, d, ok, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    q(sesr_pkg::SESR_CMD_STD_Q, `SESR_STD_RESET);
    q(sesr_pkg::SESR_CMD_STD_Q, 16'h0000);
    q(sesr_pkg::SESR_CMD_SVC_Q, 16'h0000);
    q(sesr_pkg::SESR_CMD_SEM_Q, 16'h0000);
    q(sesr_pkg::SESR_CMD_QEN_Q, 16'h0000);
    q(sesr_pkg::SESR_CMD_QEV_Q, 16'h0000);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
  endtask
  task automatic t_masks();
    w(sesr_pkg::SESR_CMD_SVC_W, 16'h00A5);
    w(sesr_pkg::SESR_CMD_SEM_W, 16'hFF5A);
    w(sesr_pkg::SESR_CMD_QEN_W, 16'hC33C);
    q(sesr_pkg::SESR_CMD_SVC_Q, 16'h00A5);
    q(sesr_pkg::SESR_CMD_SEM_Q, 16'h005A);
    q(sesr_pkg::SESR_CMD_QEN_Q, 16'hC33C);
    w(sesr_pkg::SESR_CMD_SVC_W, 16'h0000);
  endtask
  task automatic t_std();
    int pos[5] = '{`SESR_STD_OPC, `SESR_STD_QYE, `SESR_STD_DDE, `SESR_STD_EXE, `SESR_STD_CME};
    w(sesr_pkg::SESR_CMD_SEM_W, 16'h0001);
    pulse(1);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
    pulse(0);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0020);
    q(sesr_pkg::SESR_CMD_STD_Q, 16'h0005);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      q(sesr_pkg::SESR_CMD_STD_Q, 16'h0001 << pos[i]);
    end
    w(sesr_pkg::SESR_CMD_SEM_W, 16'h00FF);
    pulse(3);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0020);
    w(sesr_pkg::SESR_CMD_CLS, 16'h0000);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
    q(sesr_pkg::SESR_CMD_STD_Q, 16'h0000);
  endtask
  task automatic t_ques();
    int qp[6] = '{`SESR_QUES_VOLT, `SESR_QUES_CURR, `SESR_QUES_OHMS, `SESR_QUES_LIMLO,
                  `SESR_QUES_LIMHI, `SESR_QUES_REMOTE};
    w(sesr_pkg::SESR_CMD_QEN_W, 16'h0800);
    pulse(5);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
    pulse(8);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0008);
    q(sesr_pkg::SESR_CMD_QEV_Q, 16'h0801);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      pulse(5 + i);
      q(sesr_pkg::SESR_CMD_QEV_Q, 16'h0001 << qp[i]);
    end
    pulse(8);
    w(sesr_pkg::SESR_CMD_CLS, 16'h0000);
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
    q(sesr_pkg::SESR_CMD_QEV_Q, 16'h0000);
  endtask
  task automatic t_srq();
    logic ok;
    logic [7:0] b;
    w(sesr_pkg::SESR_CMD_SVC_W, 16'h0020);
    pulse(4);
    @(negedge clock);
    `SESR_CHK("srqOeN_q", 1'b0, srqOeN_q)
    `SESR_CHK("srqOut_q", 1'b0, srqOut_q)
    q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0060);
    `SESR_CHK("srqOeN_q", 1'b0, srqOeN_q)
    host.poll(ok, b);
    `SESR_CHK("poll", 9'h160, {ok, b})
    `SESR_CHK("srqOeN_q", 1'b1, srqOeN_q)
    host.poll(ok, b);
    `SESR_CHK("poll", 9'h120, {ok, b})
    q(sesr_pkg::SESR_CMD_STD_Q, 16'h0020);
    w(sesr_pkg::SESR_CMD_SVC_W, 16'h0000);
  endtask
  // Buffer event one cycle before the query, so the bit is seen at once
  task automatic t_mav();
    @(negedge clock);
    ev[11] = 1'b1;
    fork
      q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0010);
      begin @(negedge clock); ev[11] = 1'b0; end
    join
    @(negedge clock);
    ev[12] = 1'b1;
    fork
      q(sesr_pkg::SESR_CMD_SUM_Q, 16'h0000);
      begin @(negedge clock); ev[12] = 1'b0; end
    join
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole run is under two hundred cycles; watchdog far beyond that
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_masks();
    t_std();
    t_ques();
    t_srq();
    t_mav();
    report_and_stop();
  end
endmodule
bind sesr_status_core sesr_status_checker u_chk (.clock(clock), .rst_n(rst_n),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .rspValid_q(rspValid_q), .rspData_q(rspData_q),
  .pollReq(pollReq), .pollValid_q(pollValid_q), .pollByte_q(pollByte_q),
  .srqOut_q(srqOut_q), .srqOeN_q(srqOeN_q), .msgLoaded(msgLoaded), .termSent(termSent));
